//--- hw/iop_pkg.sv
// Constants shared by the I/O port block with tone, buzzer and PWM outputs.
// Function
// - Thirty-two bidirectional lines in four ports, each input or output.
// - Output latch keeps its written value until software rewrites it.
// - Direction bit one makes the line an input, zero a push-pull output.
// - Port read returns pad for input bits and latch for output bits.
// - Reset sets all direction bits to one, so every line is an input.
// - Bit set, clear and complement read whole port, modify, write back.
// - Every first-port input line can wake the device.
// - First-port bits share buzzer, inverted buzzer, tone, irq and timer inputs.
// - Tone option: bit 3 as output drives tone, as input stays input.
// - Tone option: latch one passes tone, latch zero holds the pin low.
// - Tone toggles on each timer overflow, half the overflow rate.
// - Tone rate is timer clock over twice (65536 minus preload).
// - Buzzer option: bits 0 and 1 as outputs drive buzzer and inverse.
// - Buzzer option: latch one passes buzzer, latch zero drives pad low; here bit 0's latch also gates bit 1 while bit 0 is an output.
// - PWM enabled: third and fourth ports carry sixteen gated PWM channels.
// - Each PWM channel has an 8-bit duty register, clocked by system clock.
// - A configuration option selects 6+2 or 7+1 PWM format.
// - 6+2 format: four subcycles of 64 clocks each.
// - 6+2 format: coarse duty from bits 7..2, dither count from bits 1..0.
// - 6+2: subcycle below dither count gets coarse plus one high clocks.
// - 7+1 format: two subcycles of 128 clocks each.
// - 7+1: coarse duty bits 7..1, dither bit 0, same dither rule.
// - Modulation rate clock over 64 or 128, full cycle clock over 256.
`default_nettype none
package iop_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 8;
   localparam int          NUM_PORTS     = 4;
   localparam int          NUM_LINES     = 32;
   localparam int          NUM_PWM       = 16;
   // Register offsets.
   localparam logic [7:0]  OFF_PORT_A    = 8'h00;
   localparam logic [7:0]  OFF_PORT_D    = 8'h03;
   localparam logic [7:0]  OFF_DIR_A     = 8'h04;
   localparam logic [7:0]  OFF_DIR_D     = 8'h07;
   localparam logic [7:0]  OFF_CFG       = 8'h08;
   localparam logic [7:0]  OFF_BITOP     = 8'h09;
   localparam logic [7:0]  OFF_WAKE_EN   = 8'h0A;
   localparam logic [7:0]  OFF_WAKE_ST   = 8'h0B;
   localparam logic [7:0]  OFF_PWM_BASE  = 8'h10;
   localparam logic [7:0]  OFF_PWM_LAST  = 8'h1F;
   // Configuration register fields.
   localparam int          CFG_TONE_EN   = 0;
   localparam int          CFG_TONE_SRC  = 1;
   localparam int          CFG_BUZ_EN    = 2;
   localparam int          CFG_PWM_EN    = 3;
   localparam int          CFG_PWM_7P1   = 4;
   localparam logic [7:0]  CFG_MASK      = 8'h1F;
   // Bit-operation command fields: op in 7:6, port in 4:3, bit in 2:0.
   localparam int          BOP_OP_LSB    = 6;
   localparam int          BOP_PORT_LSB  = 3;
   localparam logic [1:0]  BOP_SET       = 2'h1;
   localparam logic [1:0]  BOP_CLR       = 2'h2;
   localparam logic [1:0]  BOP_CPL       = 2'h3;
   // Reset values.
   localparam logic [7:0]  RST_DIR       = 8'hFF;
   localparam logic [7:0]  RST_LATCH     = 8'h00;
   localparam logic [7:0]  RST_CFG       = 8'h00;
   localparam logic [7:0]  RST_DUTY      = 8'h00;
   // First-port shared bit positions.
   localparam int          BIT_BUZ       = 0;
   localparam int          BIT_BUZ_INV   = 1;
   localparam int          BIT_TONE      = 3;
   // PWM timing in system clocks.
   localparam int          PWM_CYCLE     = 256;
   localparam int          PWM_CNT_W     = 8;
   localparam int          SUB_62_LEN    = 64;
   localparam int          SUB_71_LEN    = 128;
   // Tone counter modulus used for the timer-overflow rate.
   localparam int          TONE_MODULUS  = 65536;

   typedef enum logic [1:0] {IOP_PWM_6P2, IOP_PWM_7P1} iop_pwm_fmt_t;
endpackage
`default_nettype wire

//--- hw/iop_pwm_chan.sv
// One dithered PWM channel comparing the shared counter with its duty.
`default_nettype none
module iop_pwm_chan
   import iop_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // Shared counter, format and duty.
   input  wire logic [PWM_CNT_W-1:0] cnt_i,
   input  wire logic                 fmt_7p1_i,
   input  wire logic [7:0]           duty_i,
   // Channel level.
   output logic                      pwm_o
);
   logic [7:0] coarse_duty;
   logic [6:0] pos;
   logic [1:0] sub;
   logic [1:0] dither_count;
   logic [7:0] high_len;

   always_comb
   begin
      if (fmt_7p1_i)
      begin
         coarse_duty  = {1'b0, duty_i[7:1]};
         dither_count = {1'b0, duty_i[0]};
         sub          = {1'b0, cnt_i[7]};
         pos          = cnt_i[6:0];
      end
      else
      begin
         coarse_duty  = {2'h0, duty_i[7:2]};
         dither_count = duty_i[1:0];
         sub          = cnt_i[7:6];
         pos          = {1'b0, cnt_i[5:0]};
      end
      high_len = coarse_duty + ((sub < dither_count) ? 8'h01 : 8'h00);
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         pwm_o <= 1'b0;
      else
         pwm_o <= ({1'b0, pos} < high_len);
   end
endmodule
`default_nettype wire

//--- hw/iop_tone_gen.sv
// Tone divider: toggles on each selected timer overflow while the timer runs.
`default_nettype none
module iop_tone_gen
   import iop_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Timer side.
   input  wire logic src_i,
   input  wire logic ovf0_i,
   input  wire logic ovf1_i,
   input  wire logic timer_on_i,
   // Tone level.
   output logic      tone_o
);
   logic ovf;

   assign ovf = src_i ? ovf1_i : ovf0_i;

   // The overflow period already encodes 65536 minus the preload, so halving
   // it by a toggle gives the documented tone rate.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tone_o <= 1'b0;
      else if (!timer_on_i)
         tone_o <= 1'b0;
      else if (ovf)
         tone_o <= ~tone_o;
   end
endmodule
`default_nettype wire

//--- hw/iop_top.sv
// Four 8-bit I/O ports with tone, buzzer and sixteen-channel PWM outputs.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module iop_top
   import iop_pkg::*;
#(
   parameter int N_PWM = NUM_PWM
)
(
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // Register port.
   input  wire logic [ADDR_W-1:0]    addr_i,
   input  wire logic [DATA_W-1:0]    wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [DATA_W-1:0]    rdata_o,
   // Pads.
   input  wire logic [NUM_LINES-1:0] pad_i,
   output logic      [NUM_LINES-1:0] pad_o,
   output logic      [NUM_LINES-1:0] pad_oe_b_o,
   // Shared-function sources.
   input  wire logic                 buzzer_signal_i,
   input  wire logic                 timer_zero_ovf_i,
   input  wire logic                 timer_one_ovf_i,
   input  wire logic                 timer_on_i,
   // Shared-function inputs seen by the timers and interrupt logic.
   output logic                      external_irq_zero_o,
   output logic                      external_irq_one_o,
   output logic                      timer_zero_input_o,
   output logic                      timer_one_input_o,
   // Wake-up request.
   output logic                      wake_o
);
   logic                      rst_s1_q;
   logic                      rst_sync_b;
   logic [7:0]                latch_q   [NUM_PORTS];
   logic [7:0]                dir_q     [NUM_PORTS];
   logic [7:0]                cfg_q;
   logic [7:0]                wake_en_q;
   logic [7:0]                wake_st_q;
   logic [7:0]                duty_q    [N_PWM];
   logic [PWM_CNT_W-1:0]      pwm_cnt_q;
   logic [N_PWM-1:0]          pwm_lvl;
   logic                      tone_lvl;
   logic [NUM_LINES-1:0]      out_d;
   logic [NUM_LINES-1:0]      pad_all_q;
   logic [NUM_LINES-1:0]      latch_flat;
   logic [NUM_LINES-1:0]      dir_flat;
   logic [DATA_W-1:0]         rdata_d;
   logic                      bop_wr;
   logic [1:0]                bop_op;
   logic [1:0]                bop_port;
   logic [2:0]                bop_bit;
   logic [7:0]                bop_val;
   logic [7:0]                wake_hit;

   // Port read view: pad where input, latch where output.
   function automatic logic [7:0] port_view(input logic [7:0] pad,
                                            input logic [7:0] lat,
                                            input logic [7:0] dir);
      port_view = (pad & dir) | (lat & ~dir);
   endfunction

   // Pin level gated by the latch for a shared function.
   function automatic logic gate_fn(input logic lat, input logic fn);
      gate_fn = lat & fn;
   endfunction

   function automatic logic in_range(input logic [7:0] a,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Reset release is synchronised so all flops leave reset on one edge.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_s1_q   <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_s1_q   <= 1'b1;
         rst_sync_b <= rst_s1_q;
      end
   end

   // Flattened views of the port state.
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         latch_flat[p*8 +: 8] = latch_q[p];
         dir_flat[p*8 +: 8]   = dir_q[p];
      end
   end

   // Bit-operation decode: read whole port, modify one bit, write back.
   assign bop_wr   = wr_i && (addr_i == OFF_BITOP);
   assign bop_op   = wdata_i[BOP_OP_LSB +: 2];
   assign bop_port = wdata_i[BOP_PORT_LSB +: 2];
   assign bop_bit  = wdata_i[2:0];

   always_comb
   begin
      bop_val = port_view(pad_i[bop_port*8 +: 8], latch_q[bop_port],
                          dir_q[bop_port]);
      case (bop_op)
         BOP_SET: bop_val[bop_bit] = 1'b1;
         BOP_CLR: bop_val[bop_bit] = 1'b0;
         BOP_CPL: bop_val[bop_bit] = ~bop_val[bop_bit];
         default: bop_val = latch_q[bop_port];
      endcase
   end

   // Output latches change only on a direct write or a bit operation.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
            latch_q[p] <= RST_LATCH;
      end
      else
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            if (wr_i && addr_i == OFF_PORT_A + 8'(p))
               latch_q[p] <= wdata_i;
            else if (bop_wr && bop_op != 2'h0 && bop_port == 2'(p))
               latch_q[p] <= bop_val;
         end
      end
   end

   // Direction registers start as all inputs.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
            dir_q[p] <= RST_DIR;
      end
      else
      begin
         for (int p = 0; p < NUM_PORTS; p++)
            if (wr_i && addr_i == OFF_DIR_A + 8'(p))
               dir_q[p] <= wdata_i;
      end
   end

   // Option register: tone, buzzer, PWM enable and PWM format.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         cfg_q <= RST_CFG;
      else if (wr_i && addr_i == OFF_CFG)
         cfg_q <= wdata_i & CFG_MASK;
   end

   // Duty registers, one per channel.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         for (int c = 0; c < N_PWM; c++)
            duty_q[c] <= RST_DUTY;
      end
      else
      begin
         for (int c = 0; c < N_PWM; c++)
            if (wr_i && addr_i == OFF_PWM_BASE + 8'(c))
               duty_q[c] <= wdata_i;
      end
   end

   // Free-running PWM counter; one wrap is one full 256-clock PWM cycle.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         pwm_cnt_q <= '0;
      else
         pwm_cnt_q <= pwm_cnt_q + 8'h01;
   end

   for (genvar c = 0; c < N_PWM; c++)
   begin : g_pwm
      iop_pwm_chan u_chan (
         .clk_i     (clk_i),
         .rst_b_i   (rst_sync_b),
         .cnt_i     (pwm_cnt_q),
         .fmt_7p1_i (cfg_q[CFG_PWM_7P1]),
         .duty_i    (duty_q[c]),
         .pwm_o     (pwm_lvl[c])
      );
   end

   iop_tone_gen u_tone (
      .clk_i      (clk_i),
      .rst_b_i    (rst_sync_b),
      .src_i      (cfg_q[CFG_TONE_SRC]),
      .ovf0_i     (timer_zero_ovf_i),
      .ovf1_i     (timer_one_ovf_i),
      .timer_on_i (timer_on_i),
      .tone_o     (tone_lvl)
   );

   // Pin output levels before the output flops.
   always_comb
   begin
      out_d = latch_flat;
      if (cfg_q[CFG_TONE_EN])
         out_d[BIT_TONE] = gate_fn(latch_q[0][BIT_TONE],
                                   tone_lvl);
      if (cfg_q[CFG_BUZ_EN])
      begin
         out_d[BIT_BUZ] = gate_fn(latch_q[0][BIT_BUZ],
                                  buzzer_signal_i);
         // While bit 0 drives, its latch gates the pair, so the two pads are
         // complementary when that latch is one and both low when it is zero.
         if (!dir_q[0][BIT_BUZ])
            out_d[BIT_BUZ_INV] = gate_fn(latch_q[0][BIT_BUZ],
                                         ~buzzer_signal_i);
         else
            out_d[BIT_BUZ_INV] = gate_fn(latch_q[0][BIT_BUZ_INV],
                                         ~buzzer_signal_i);
      end
      if (cfg_q[CFG_PWM_EN])
      begin
         for (int c = 0; c < N_PWM; c++)
            out_d[16 + c] = gate_fn(latch_flat[16 + c],
                                    pwm_lvl[c]);
      end
   end

   // Pads: enable low drives; direction bit one releases the pad.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         pad_o      <= '0;
         pad_oe_b_o <= '1;
      end
      else
      begin
         pad_o      <= out_d;
         pad_oe_b_o <= dir_flat;
      end
   end

   // Registered pads for wake detection; the reset level matches the
   // pulled-up idle level so leaving reset raises no false edge.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         pad_all_q <= '1;
      else
         pad_all_q <= pad_i;
   end

   // First-port shared inputs always follow the pads.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         external_irq_zero_o <= 1'b1;
         external_irq_one_o  <= 1'b1;
         timer_zero_input_o  <= 1'b0;
         timer_one_input_o   <= 1'b0;
      end
      else
      begin
         external_irq_zero_o <= pad_i[5];
         external_irq_one_o  <= pad_i[6];
         timer_zero_input_o  <= pad_i[4];
         timer_one_input_o   <= pad_i[7];
      end
   end

   // Wake-up: any enabled first-port input line that changes level.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         wake_en_q <= 8'h00;
      else if (wr_i && addr_i == OFF_WAKE_EN)
         wake_en_q <= wdata_i;
   end

   assign wake_hit = (pad_i[7:0] ^ pad_all_q[7:0]) & wake_en_q & dir_q[0];

   // Sticky wake status; a new hit wins over a clear in the same cycle.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         wake_st_q <= 8'h00;
      else if (wr_i && addr_i == OFF_WAKE_ST)
         wake_st_q <= (wake_st_q & ~wdata_i) | wake_hit;
      else
         wake_st_q <= wake_st_q | wake_hit;
   end

   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         wake_o <= 1'b0;
      else
         wake_o <= |wake_hit;
   end

   // Read mux; the first pad stage is not latched, so the value is taken
   // from the pad in the strobe cycle.
   always_comb
   begin
      rdata_d = 8'h00;
      if (addr_i <= OFF_PORT_D)
         rdata_d = port_view(pad_i[addr_i[1:0]*8 +: 8],
                             latch_q[addr_i[1:0]],
                             dir_q[addr_i[1:0]]);
      else if (in_range(addr_i, OFF_DIR_A, OFF_DIR_D))
         rdata_d = dir_q[addr_i[1:0]];
      else if (addr_i == OFF_CFG)
         rdata_d = cfg_q;
      else if (addr_i == OFF_WAKE_EN)
         rdata_d = wake_en_q;
      else if (addr_i == OFF_WAKE_ST)
         rdata_d = wake_st_q;
      else if (in_range(addr_i, OFF_PWM_BASE, OFF_PWM_LAST))
         rdata_d = duty_q[addr_i[3:0]];
   end

   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         rdata_o <= 8'h00;
      else if (rd_i)
         rdata_o <= rdata_d;
      else
         rdata_o <= 8'h00;
   end
endmodule
`default_nettype wire

//--- bench/iop_top_assertions.sv
// Port-level assertions for the I/O port block.
`default_nettype none
module iop_chk
   import iop_pkg::*;
(
   // Clock, reset and register port.
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic [ADDR_W-1:0]    addr_i,
   input wire logic [DATA_W-1:0]    wdata_i,
   input wire logic                 wr_i,
   input wire logic                 rd_i,
   input wire logic [DATA_W-1:0]    rdata_o,
   // Pads and shared inputs.
   input wire logic [NUM_LINES-1:0] pad_i,
   input wire logic [NUM_LINES-1:0] pad_o,
   input wire logic [NUM_LINES-1:0] pad_oe_b_o,
   input wire logic                 external_irq_zero_o,
   input wire logic                 external_irq_one_o,
   input wire logic                 timer_zero_input_o,
   input wire logic                 timer_one_input_o,
   input wire logic                 wake_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] run_q;
   logic       run;

   // The design leaves reset two edges late; waiting longer keeps $past
   // from looking back into the reset.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         run_q <= 3'h0;
      else if (run_q != 3'h4)
         run_q <= run_q + 3'h1;
   end
   assign run = run_q == 3'h4;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence dir_wr_s;
      wr_i && addr_i[7:2] == 6'h01;
   endsequence

   reset_pads_a: assert property (
      !run |-> pad_oe_b_o == 32'hFFFFFFFF && pad_o == 32'h0)
      else $error("Pads left their reset state early.");
   dir_write_a: assert property (dir_wr_s |-> ##2
      8'(pad_oe_b_o >> {$past(addr_i[1:0], 2), 3'h0}) == $past(wdata_i, 2))
      else $error("Pad enables do not follow the direction write.");
   dir_hold_a: assert property (
      !$past(wr_i, 2) |-> $stable(pad_oe_b_o))
      else $error("Pad enables changed without a write.");
   latch_drive_a: assert property (wr_i && addr_i == 8'h01 |-> ##2
      ((pad_o[15:8] ^ $past(wdata_i, 2)) & ~pad_oe_b_o[15:8]) == 8'h00)
      else $error("Output pads do not show the written latch.");
   port_read_a: assert property (
      rd_i && addr_i == 8'h01 && !$past(wr_i) && run |=> rdata_o ==
      $past((pad_i[15:8] & pad_oe_b_o[15:8])
      | (pad_o[15:8] & ~pad_oe_b_o[15:8])))
      else $error("Port read mixes pad and latch wrongly.");
   read_idle_a: assert property (
      !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("Read data outside the read answer cycle.");
   unmapped_read_a: assert property (rd_i && (addr_i == OFF_BITOP
      || addr_i[7:2] == 6'h03 || addr_i[7:5] != 3'h0) |=> rdata_o == 8'h00)
      else $error("Unmapped or write-only address read non-zero.");
   shared_in_a: assert property (run |-> {external_irq_zero_o,
      external_irq_one_o, timer_zero_input_o, timer_one_input_o}
      == $past({pad_i[5], pad_i[6], pad_i[4], pad_i[7]}))
      else $error("Shared inputs do not copy their pads.");
   wake_cause_a: assert property (wake_o |->
      |(($past(pad_i[7:0]) ^ $past(pad_i[7:0], 2)) & pad_oe_b_o[7:0]))
      else $error("Wake pulse without a first-port input change.");
endmodule

bind iop_top iop_chk u_chk (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .pad_i, .pad_o, .pad_oe_b_o, .external_irq_zero_o,
   .external_irq_one_o, .timer_zero_input_o, .timer_one_input_o, .wake_o);
`default_nettype wire

//--- bench/iop_pins.sv
// Board model of the pads: outside drivers and pull-up resistors.
`default_nettype none
module iop_pins
   import iop_pkg::*;
(
   // Device side.
   input  wire logic [NUM_LINES-1:0] pad_out_i,
   input  wire logic [NUM_LINES-1:0] pad_oe_b_i,
   // Outside drivers, changed only just after a clock edge.
   input  wire logic [NUM_LINES-1:0] ext_i,
   input  wire logic [NUM_LINES-1:0] ext_en_i,
   // Resolved pad level.
   output logic      [NUM_LINES-1:0] level_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // An undriven line rises through its pull-up instead of keeping the
   // last value, so a stale level is never read back by luck.
   assign level_o = (~pad_oe_b_i & pad_out_i)
      | (pad_oe_b_i & ext_en_i & ext_i)
      | (pad_oe_b_i & ~ext_en_i);
endmodule
`default_nettype wire

//--- bench/iop_top_test.sv
// Self-checking bench for the I/O port block with tone, buzzer and PWM.
`default_nettype none
module iop_top_test
   import iop_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk_i   = 1'b0;
   logic                 rst_b_i = 1'b0;
   logic [ADDR_W-1:0]    addr_i  = 8'h00;
   logic [DATA_W-1:0]    wdata_i = 8'h00;
   logic                 wr_i    = 1'b0;
   logic                 rd_i    = 1'b0;
   logic                 buz     = 1'b0;
   logic                 ovf0    = 1'b0;
   logic                 ovf1    = 1'b0;
   logic                 t_on    = 1'b0;
   logic [NUM_LINES-1:0] ext     = 32'h0;
   logic [DATA_W-1:0]    rdata_o;
   logic [NUM_LINES-1:0] pad_i;
   logic [NUM_LINES-1:0] pad_o;
   logic [NUM_LINES-1:0] pad_oe_b_o;
   logic                 wake;
   logic [DATA_W-1:0]    exp_q[$];
   int                   errors = 0;
   int                   checks = 0;

   iop_top uut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .pad_i, .pad_o, .pad_oe_b_o, .buzzer_signal_i(buz),
      .timer_zero_ovf_i(ovf0), .timer_one_ovf_i(ovf1), .timer_on_i(t_on),
      .external_irq_zero_o(), .external_irq_one_o(),
      .timer_zero_input_o(), .timer_one_input_o(), .wake_o(wake));
   // Third and fourth ports are left to their pull-ups when released.
   iop_pins board (.pad_out_i(pad_o), .pad_oe_b_i(pad_oe_b_o),
      .ext_i(ext), .ext_en_i(32'h0000FFFF), .level_o(pad_i));

   initial
   begin
      forever
         #12.5 clk_i = ~clk_i;
   end

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Each access leaves one idle cycle so no strobe is driven twice.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      logic pend;
      pend = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (pend)
            chk("rdata", exp_q.pop_front(), rdata_o);
         pend = rd_i;
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      end_of_test();
   end

   initial
   begin
      logic [7:0]  d, l, v, n;
      logic [7:0]  duty [16];
      logic [15:0] prev;
      int          hi [16];
      int          ri [16];
      void'($urandom(96));
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      tick(4);
      for (int i = 0; i < 4; i++)
      begin
         rd(OFF_DIR_A + 8'(i), RST_DIR);
         rd(8'(i), i < 2 ? 8'h00 : 8'hFF);
      end
      rd(OFF_CFG, RST_CFG);
      rd(OFF_PWM_LAST, RST_DUTY);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      rd(8'h0C, 8'h00);
      rd(OFF_BITOP, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         d = 8'($urandom);
         l = 8'($urandom);
         v = 8'($urandom);
         ext[15:8] <= v;
         wr(8'h05, d);
         wr(8'h01, l);
         rd(8'h01, (v & d) | (l & ~d));
         rd(8'h05, d);
      end
      // Input bits of the port are folded into the latch by a bit operation.
      for (int op = 1; op < 4; op++)
      begin
         l = 8'($urandom);
         v = 8'($urandom);
         n = 8'h01 << 3'($urandom);
         ext[15:8] <= v;
         wr(8'h05, 8'hF0);
         wr(8'h01, l);
         wr(OFF_BITOP, {2'(op), 3'h1, 3'($clog2(n))});
         wr(8'h05, 8'h00);
         v = (v & 8'hF0) | (l & 8'h0F);
         v = op == 1 ? v | n : op == 2 ? v & ~n : v ^ n;
         rd(8'h01, v);
      end
      wr(OFF_WAKE_EN, 8'hFF);
      for (int i = 0; i < 8; i++)
      begin
         wr(OFF_WAKE_ST, 8'hFF);
         ext[i] <= ~ext[i];
         tick(2);
         chk("wake", 8'h01, {7'h0, wake});
         tick(2);
         rd(OFF_WAKE_ST, 8'h01 << i);
      end
      wr(8'h04, 8'hF7);
      for (int s = 0; s < 4; s++)
      begin
         wr(OFF_CFG, s ? 8'h03 : 8'h01);
         wr(8'h00, s == 2 ? 8'h00 : 8'h08);
         t_on <= s != 3;
         tick(4);
         prev[0] = pad_o[3];
         hi[0] = 0;
         for (int p = 0; p < 56; p++)
         begin
            ovf0 <= p < 48 && p % 4 == 0;
            ovf1 <= p < 48 && p % 6 == 0;
            @(posedge clk_i);
            hi[0] += int'(pad_o[3] !== prev[0]);
            prev[0] = pad_o[3];
         end
         chk("tone", s ? (s == 1 ? 8'h08 : 8'h00) : 8'h0C,
            8'(hi[0]));
         if (s > 1)
            chk("tone_low", 8'h00, {7'h0, pad_o[3]});
      end
      wr(OFF_CFG, 8'h04);
      wr(8'h04, 8'hFC);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h00, k[1] ? 8'h01 : 8'h02);
         buz <= k[0];
         tick(4);
         chk("buzzer", k[1] ? {6'h0, ~k[0], k[0]} : 8'h00,
            {6'h0, pad_o[1:0]});
      end
      wr(8'h06, 8'h00);
      wr(8'h07, 8'h00);
      wr(8'h02, 8'hFE);
      wr(8'h03, 8'hFF);
      for (int f = 0; f < 2; f++)
      begin
         wr(OFF_CFG, f ? 8'h18 : 8'h08);
         for (int c = 0; c < 16; c++)
         begin
            duty[c] = 8'($urandom_range(247, 8));
            wr(OFF_PWM_BASE + 8'(c), duty[c]);
            rd(OFF_PWM_BASE + 8'(c), duty[c]);
            hi[c] = 0;
            ri[c] = 0;
         end
         tick(300);
         prev = pad_o[31:16];
         repeat (256)
         begin
            @(posedge clk_i);
            for (int c = 0; c < 16; c++)
            begin
               hi[c] += int'(pad_o[16 + c]);
               ri[c] += int'(pad_o[16 + c] & ~prev[c]);
            end
            prev = pad_o[31:16];
         end
         for (int c = 0; c < 16; c++)
         begin
            chk("pwm_high", c ? duty[c] : 8'h00,
               8'(hi[c]));
            chk("pwm_rise", c ? (f ? 8'h02 : 8'h04) : 8'h00,
               8'(ri[c]));
         end
      end
      end_of_test();
   end
endmodule
`default_nettype wire
